// file: hw/weight_signal_conditioning.sv
// Weight signal conditioning: filter, pacing, motion, zero tracking, units and APB registers
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module weight_signal_conditioning
  import wsc_pkg::*;
#(
  parameter int          W           = 24,
  parameter int unsigned TENTH_COUNT = TENTH_CYCLES
) (
  // APB slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // A/D front end
  input  wire logic                adc_valid,
  input  wire logic [W-1:0]        adc_data,
  output logic      [7:0]          adc_gain,
  // Keypad and lock switch
  input  wire logic                zero_key,
  input  wire logic                units_key,
  input  wire logic                lock_unlocked,
  // Display and status
  output wsc_pkg::disp_t           disp,
  output logic                     motion,
  output logic                     cal_start
);
  import wsc_pkg::*;

  typedef enum logic [1:0] {IDLE, DIVIDE, DONE} div_state_t;

  // Settings
  logic [7:0]   sens_q, filter_q, update_q, mdelay_q, mband_q, blank_q, ztdelay_q, ztband_q;
  logic [7:0]   pbzpct_q, punits_q, pdec_q, pcountby_q, aunits_q, adec_q, acountby_q;
  logic [W-1:0] fsweight_q;
  logic         pw2_q;
  logic         level3;
  // Datapath state
  logic [W+4:0] filt_q;
  logic [W-1:0] zero_q, sample_q, prev_q;
  logic [4:0]   zt_frac_q;
  logic [7:0]   zt_cnt_q;
  logic         alt_q, motion_q, moving_q, zt_active_q, upd_pulse_q;
  logic [31:0]  tick_q;
  logic [7:0]   tenth_q, mstable_q;
  logic [W-1:0] grads_q, div_rem_q, quot_q;
  logic [4:0]   div_bit_q;
  div_state_t   div_state_q;
  logic         apb_wr, apb_rd;

  // Saturating clamp of a write to a setting's maximum
  function automatic logic [7:0] clamp(input logic [31:0] v, input logic [7:0] mx);
    clamp = (v > 32'(mx)) ? mx : v[7:0];
  endfunction

  // Absolute difference of two weights
  function automatic logic [W-1:0] absdiff(input logic [W-1:0] a, input logic [W-1:0] b);
    absdiff = ($signed(a) > $signed(b)) ? a - b : b - a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB access, zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign level3 = pw2_q && lock_unlocked;

  // Settings registers with factory defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_q     <= DEF_SENS;
      filter_q   <= DEF_FILTER;
      update_q   <= DEF_UPDATE;
      mdelay_q   <= DEF_MDELAY;
      mband_q    <= DEF_MBAND;
      blank_q    <= DEF_BLANK;
      ztdelay_q  <= DEF_ZTDELAY;
      ztband_q   <= DEF_ZTBAND;
      pbzpct_q   <= DEF_PBZPCT;
      punits_q   <= DEF_PUNITS;
      pdec_q     <= DEF_PDEC;
      pcountby_q <= DEF_PCOUNTBY;
      aunits_q   <= DEF_AUNITS;
      adec_q     <= DEF_ADEC;
      acountby_q <= DEF_ACOUNTBY;
      fsweight_q <= W'(DEF_FSWEIGHT);
      pw2_q      <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        OFS_SENS:     sens_q     <= clamp(pwdata, MAX_SENS);
        OFS_FILTER:   filter_q   <= clamp(pwdata, MAX_FILTER);
        OFS_UPDATE:   update_q   <= (pwdata == 32'h0) ? 8'h01 : clamp(pwdata, MAX_UPDATE);
        OFS_MDELAY:   mdelay_q   <= pwdata[7:0];
        OFS_MBAND:    mband_q    <= pwdata[7:0];
        OFS_BLANK:    blank_q    <= {7'h0, pwdata[0]};
        OFS_ZTDELAY:  ztdelay_q  <= pwdata[7:0];
        OFS_ZTBAND:   ztband_q   <= pwdata[7:0];
        OFS_PBZPCT:   pbzpct_q   <= (pwdata == 32'h0) ? 8'h01 : clamp(pwdata, MAX_PCT);
        OFS_PUNITS:   punits_q   <= clamp(pwdata, MAX_UNITS);
        OFS_PDEC:     pdec_q     <= clamp(pwdata, MAX_DEC);
        OFS_PCOUNTBY: pcountby_q <= (pwdata == 32'h0) ? 8'h01 : clamp(pwdata, MAX_COUNTBY);
        OFS_AUNITS:   aunits_q   <= clamp(pwdata, MAX_UNITS);
        OFS_ADEC:     adec_q     <= clamp(pwdata, MAX_DEC);
        OFS_ACOUNTBY: acountby_q <= (pwdata == 32'h0) ? 8'h01 : clamp(pwdata, MAX_COUNTBY);
        OFS_FSWEIGHT: fsweight_q <= pwdata[W-1:0];
        OFS_ACCESS:   pw2_q      <= pwdata[ACC_PW2_BIT];
        default:      pw2_q      <= pw2_q;
      endcase
    end
  end

  // Read mux and response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > OFS_GRADS || paddr[1:0] != 2'b00 ||
                 (pwrite && paddr > OFS_CALFN));
      if (apb_rd) begin
        case (paddr)
          OFS_SENS:     prdata <= {24'h0, sens_q};
          OFS_FILTER:   prdata <= {24'h0, filter_q};
          OFS_UPDATE:   prdata <= {24'h0, update_q};
          OFS_MDELAY:   prdata <= {24'h0, mdelay_q};
          OFS_MBAND:    prdata <= {24'h0, mband_q};
          OFS_BLANK:    prdata <= {24'h0, blank_q};
          OFS_ZTDELAY:  prdata <= {24'h0, ztdelay_q};
          OFS_ZTBAND:   prdata <= {24'h0, ztband_q};
          OFS_PBZPCT:   prdata <= {24'h0, pbzpct_q};
          OFS_PUNITS:   prdata <= {24'h0, punits_q};
          OFS_PDEC:     prdata <= {24'h0, pdec_q};
          OFS_PCOUNTBY: prdata <= {24'h0, pcountby_q};
          OFS_AUNITS:   prdata <= {24'h0, aunits_q};
          OFS_ADEC:     prdata <= {24'h0, adec_q};
          OFS_ACOUNTBY: prdata <= {24'h0, acountby_q};
          OFS_FSWEIGHT: prdata <= 32'(fsweight_q);
          OFS_ACCESS:   prdata <= {30'h0, lock_unlocked, pw2_q};
          OFS_STATUS:   prdata <= {25'h0, zt_active_q, 1'b0, cal_start, level3,
                                   alt_q, disp.blank, motion_q};
          OFS_WEIGHT:   prdata <= 32'($signed(sample_q));
          OFS_ZERO:     prdata <= 32'($signed(zero_q));
          OFS_GRADS:    prdata <= 32'(grads_q);
          default:      prdata <= 32'h0;
        endcase
      end
    end
  end

  // Calibration launch, only with level 3 access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= apb_wr && paddr == OFS_CALFN && level3 &&
                   pwdata[7:0] >= CAL_FN_LO && pwdata[7:0] <= CAL_FN_HI;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_gain <= GAIN_50;
    end else begin
      case (sens_q)
        8'h00:         adc_gain <= GAIN_200;
        8'h01, 8'h02:  adc_gain <= GAIN_100;
        8'h03:         adc_gain <= GAIN_50;
        default:       adc_gain <= GAIN_25;
      endcase
    end
  end

  // Recursive filter: shift of filter/3 rounded up, plus 1, gives a doubling settle per 3 steps
  logic [2:0] fshift;
  assign fshift = 3'((filter_q + 8'h2) / 8'h3);
  logic signed [W+4:0] fdiff;
  assign fdiff = $signed(((W+5)'($signed(adc_data)) <<< 5) - filt_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= '0;
    end else if (adc_valid) begin
      if (filter_q == 8'h0) begin
        filt_q <= (W+5)'($signed(adc_data)) <<< 5;
      end else begin
        filt_q <= filt_q + (W+5)'(fdiff >>> (fshift + 3'h1));
      end
    end
  end

  // Display update pacing in tenths of a second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q      <= 32'h0;
      tenth_q     <= 8'h0;
      upd_pulse_q <= 1'b0;
    end else begin
      upd_pulse_q <= 1'b0;
      if (tick_q >= 32'(TENTH_COUNT - 1)) begin
        tick_q <= 32'h0;
        if (tenth_q + 8'h1 >= update_q) begin
          tenth_q     <= 8'h0;
          upd_pulse_q <= 1'b1;
        end else begin
          tenth_q <= tenth_q + 8'h1;
        end
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end

  // Sample capture at update rate, net of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= '0;
      prev_q   <= '0;
    end else if (upd_pulse_q) begin
      prev_q   <= sample_q;
      sample_q <= W'($signed(filt_q) >>> 5) - zero_q;
    end
  end

  // Motion detection with band in quarter divisions and stable delay
  logic [W+1:0] delta4, mband_w;
  assign delta4  = {absdiff(sample_q, prev_q), 2'b00};
  assign mband_w = (W+2)'(mband_q) * (W+2)'(pcountby_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving_q  <= 1'b0;
      motion_q  <= 1'b0;
      mstable_q <= 8'h0;
    end else if (mdelay_q == 8'h0) begin
      moving_q  <= 1'b0;
      motion_q  <= 1'b0;
      mstable_q <= 8'h0;
    end else begin
      if (upd_pulse_q) begin
        moving_q <= delta4 > mband_w;
      end
      if (moving_q) begin
        motion_q  <= 1'b1;
        mstable_q <= 8'h0;
      end else if (tick_q == 32'h0 && motion_q) begin
        if (mstable_q >= mdelay_q) begin
          motion_q <= 1'b0;
        end else begin
          mstable_q <= mstable_q + 8'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero tracking and push-button zero
  logic [W+1:0] abs4, ztband_w;
  logic [W+6:0] lim100, pct_w;
  assign abs4     = {absdiff(sample_q, '0), 2'b00};
  assign ztband_w = (W+2)'(ztband_q) * (W+2)'(pcountby_q);
  assign lim100   = (W+7)'(absdiff(sample_q, '0)) * (W+7)'(MAX_PCT);
  assign pct_w    = (W+7)'(fsweight_q) * (W+7)'(pbzpct_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_q      <= '0;
      zt_frac_q   <= 5'h0;
      zt_cnt_q    <= 8'h0;
      zt_active_q <= 1'b0;
    end else begin
      zt_active_q <= ztband_q != 8'h0 && !motion_q && abs4 <= ztband_w;
      if (zero_key && lim100 <= pct_w) begin
        zero_q <= zero_q + sample_q;
        zt_cnt_q <= 8'h0;
      end else if (adc_valid && zt_active_q) begin
        if (zt_cnt_q >= ztdelay_q) begin
          zt_cnt_q <= 8'h0;
          if (zt_frac_q >= 5'(ZT_FRAC_DEN - 1)) begin
            zt_frac_q <= 5'h0;
            zero_q <= $signed(sample_q) > 0 ? zero_q + W'(pcountby_q)
                    : ($signed(sample_q) < 0 ? zero_q - W'(pcountby_q) : zero_q);
          end else begin
            zt_frac_q <= zt_frac_q + 5'h1;
          end
        end else begin
          zt_cnt_q <= zt_cnt_q + 8'h1;
        end
      end
    end
  end

  // Units toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_q <= 1'b0;
    end else if (units_key) begin
      alt_q <= !alt_q;
    end
  end

  // Full-scale graduations by restoring division
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grads_q     <= '0;
      quot_q      <= '0;
      div_rem_q   <= '0;
      div_bit_q   <= 5'h0;
      div_state_q <= IDLE;
    end else begin
      case (div_state_q)
        IDLE: begin
          div_rem_q   <= '0;
          quot_q      <= fsweight_q;
          div_bit_q   <= 5'(W - 1);
          div_state_q <= DIVIDE;
        end
        DIVIDE: begin
          if ({div_rem_q[W-2:0], quot_q[W-1]} >= W'(pcountby_q)) begin
            div_rem_q <= {div_rem_q[W-2:0], quot_q[W-1]} - W'(pcountby_q);
            quot_q    <= {quot_q[W-2:0], 1'b1};
          end else begin
            div_rem_q <= {div_rem_q[W-2:0], quot_q[W-1]};
            quot_q    <= {quot_q[W-2:0], 1'b0};
          end
          if (div_bit_q == 5'h0) begin
            div_state_q <= DONE;
          end else begin
            div_bit_q <= div_bit_q - 5'h1;
          end
        end
        DONE: begin
          grads_q     <= quot_q;
          div_state_q <= IDLE;
        end
        default: div_state_q <= IDLE;
      endcase
    end
  end

  // Display output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp   <= '0;
      motion <= 1'b0;
    end else begin
      motion         <= motion_q;
      disp.weight    <= 24'($signed(sample_q));
      disp.blank     <= blank_q[0] && motion_q;
      disp.alt_units <= alt_q;
      disp.units     <= alt_q ? aunits_q[3:0] : punits_q[3:0];
      disp.dec_pos   <= alt_q ? adec_q[2:0] : pdec_q[2:0];
      disp.count_by  <= alt_q ? acountby_q : pcountby_q;
    end
  end
endmodule

// file: hw/wsc_pkg.sv
// Package: register map, field layouts, defaults and timing for weight conditioning
package wsc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SENS      = 8'h00;
  localparam logic [7:0] OFS_FILTER    = 8'h04;
  localparam logic [7:0] OFS_UPDATE    = 8'h08;
  localparam logic [7:0] OFS_MDELAY    = 8'h0c;
  localparam logic [7:0] OFS_MBAND     = 8'h10;
  localparam logic [7:0] OFS_BLANK     = 8'h14;
  localparam logic [7:0] OFS_ZTDELAY   = 8'h18;
  localparam logic [7:0] OFS_ZTBAND    = 8'h1c;
  localparam logic [7:0] OFS_PBZPCT    = 8'h20;
  localparam logic [7:0] OFS_PUNITS    = 8'h24;
  localparam logic [7:0] OFS_PDEC      = 8'h28;
  localparam logic [7:0] OFS_PCOUNTBY  = 8'h2c;
  localparam logic [7:0] OFS_AUNITS    = 8'h30;
  localparam logic [7:0] OFS_ADEC      = 8'h34;
  localparam logic [7:0] OFS_ACOUNTBY  = 8'h38;
  localparam logic [7:0] OFS_FSWEIGHT  = 8'h3c;
  localparam logic [7:0] OFS_ACCESS    = 8'h40;
  localparam logic [7:0] OFS_CALFN     = 8'h44;
  localparam logic [7:0] OFS_STATUS    = 8'h48;
  localparam logic [7:0] OFS_WEIGHT    = 8'h4c;
  localparam logic [7:0] OFS_ZERO      = 8'h50;
  localparam logic [7:0] OFS_GRADS     = 8'h54;
  // Factory defaults
  localparam logic [7:0]  DEF_SENS     = 8'h03;
  localparam logic [7:0]  DEF_FILTER   = 8'h09;
  localparam logic [7:0]  DEF_UPDATE   = 8'h01;
  localparam logic [7:0]  DEF_MDELAY   = 8'h06;
  localparam logic [7:0]  DEF_MBAND    = 8'h06;
  localparam logic [7:0]  DEF_BLANK    = 8'h00;
  localparam logic [7:0]  DEF_ZTDELAY  = 8'h00;
  localparam logic [7:0]  DEF_ZTBAND   = 8'h0c;
  localparam logic [7:0]  DEF_PBZPCT   = 8'h64;
  localparam logic [7:0]  DEF_PUNITS   = 8'h01;
  localparam logic [7:0]  DEF_PDEC     = 8'h00;
  localparam logic [7:0]  DEF_PCOUNTBY = 8'h01;
  localparam logic [7:0]  DEF_AUNITS   = 8'h02;
  localparam logic [7:0]  DEF_ADEC     = 8'h01;
  localparam logic [7:0]  DEF_ACOUNTBY = 8'h05;
  localparam logic [23:0] DEF_FSWEIGHT = 24'h002710;
  // Limits
  localparam logic [7:0] MAX_SENS    = 8'h04;
  localparam logic [7:0] MAX_FILTER  = 8'h12;
  localparam logic [7:0] MAX_UPDATE  = 8'hc8;
  localparam logic [7:0] MAX_PCT     = 8'h64;
  localparam logic [7:0] MAX_UNITS   = 8'h08;
  localparam logic [7:0] MAX_DEC     = 8'h04;
  localparam logic [7:0] MAX_COUNTBY = 8'h64;
  localparam logic [7:0] CAL_FN_LO   = 8'h3c;
  localparam logic [7:0] CAL_FN_HI   = 8'h3f;
  // Access register fields
  localparam int ACC_PW2_BIT    = 0;
  localparam int ACC_UNLOCK_BIT = 1;
  // Status register fields
  localparam int ST_MOTION_BIT  = 0;
  localparam int ST_BLANK_BIT   = 1;
  localparam int ST_ALT_BIT     = 2;
  localparam int ST_LEVEL3_BIT  = 3;
  localparam int ST_CALREF_BIT  = 4;
  localparam int ST_ZREF_BIT    = 5;
  localparam int ST_ZTRACK_BIT  = 6;
  // Gain codes
  localparam logic [7:0] GAIN_200 = 8'hc8;
  localparam logic [7:0] GAIN_100 = 8'h64;
  localparam logic [7:0] GAIN_50  = 8'h32;
  localparam logic [7:0] GAIN_25  = 8'h19;
  // Zero tracking step is 1/30 display digit
  localparam int ZT_FRAC_DEN = 30;
  // Timing
  localparam int  CLK_HZ          = 200_000_000;
  localparam real TENTH_SEC       = 0.1;
  localparam int  TENTH_CYCLES    = int'(TENTH_SEC * CLK_HZ);
  // Display output bundle
  typedef struct packed {
    logic [23:0] weight;
    logic        blank;
    logic        alt_units;
    logic [3:0]  units;
    logic [2:0]  dec_pos;
    logic [7:0]  count_by;
  } disp_t;
endpackage

// file: tb/weight_signal_conditioning_tb_top.sv
// Directed bench for the weight conditioning block
`timescale 1ns/10ps
module weight_signal_conditioning_tb_top;
  import wsc_pkg::*;
  localparam int LIMIT = 20000;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic           adc_valid, zero_key, units_key, lock_unlocked, motion, cal_start;
  logic [7:0]     paddr, adc_gain;
  logic [31:0]    pwdata, prdata, r;
  logic [23:0]    adc_data, load;
  wsc_pkg::disp_t disp;
  int             n_fail = 0, num_checks = 0, cyc = 0, mot_cnt = 0, blk_cnt = 0;
  int             cal_cnt = 0, m, b;
  logic [31:0]    defs [16] = '{DEF_SENS, DEF_FILTER, DEF_UPDATE, DEF_MDELAY, DEF_MBAND,
    DEF_BLANK, DEF_ZTDELAY, DEF_ZTBAND, DEF_PBZPCT, DEF_PUNITS, DEF_PDEC, DEF_PCOUNTBY,
    DEF_AUNITS, DEF_ADEC, DEF_ACOUNTBY, DEF_FSWEIGHT};
  logic [7:0]     gx [5] = '{GAIN_200, GAIN_100, GAIN_100, GAIN_50, GAIN_25};
  int             lv [5] = '{100, 102, 105, 300, 600};
  bit             em [5] = '{1, 0, 1, 1, 0};
  bit             eb [5] = '{1, 0, 1, 0, 0};

  weight_signal_conditioning #(.TENTH_COUNT(10)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_valid(adc_valid), .adc_data(adc_data), .adc_gain(adc_gain), .zero_key(zero_key),
    .units_key(units_key), .lock_unlocked(lock_unlocked), .disp(disp), .motion(motion),
    .cal_start(cal_start)
  );
  wsc_adc_model #(.W(24), .CONV(4)) i_adc (
    .pclk(pclk), .presetn(presetn), .load(load), .adc_valid(adc_valid), .adc_data(adc_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  // Cycle count, event tallies, hang guard
  always @(posedge pclk) begin
    cyc++;
    if (motion === 1'b1) mot_cnt++;
    if (disp.blank === 1'b1) blk_cnt++;
    if (cal_start === 1'b1) cal_cnt++;
    if (cyc == LIMIT) begin
      n_fail++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), r, x);
  endtask
  task automatic press(input bit u);
    if (u) units_key <= 1'b1;
    else zero_key <= 1'b1;
    @(posedge pclk);
    units_key <= 1'b0; zero_key <= 1'b0;
    repeat (30) @(posedge pclk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, zero_key, units_key, lock_unlocked, presetn} = '0;
    paddr = '0; pwdata = '0; load = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (defs[i]) rd(8'(i * 4), defs[i]);
    chk("gain_rst", adc_gain, GAIN_50);
    $display("test defaults done");
    foreach (gx[i]) begin
      wr(OFS_SENS, i);
      @(posedge pclk);
      chk("adc_gain", adc_gain, gx[i]);
    end
    wr(OFS_SENS, 32'h7);
    rd(OFS_SENS, 32'h4);
    wr(OFS_FILTER, 32'h13);
    rd(OFS_FILTER, 32'h12);
    apb(1'b0, 8'h58, 32'h0);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    apb(1'b1, OFS_STATUS, 32'hff);
    chk("ro_write", e, 1'b1);
    $display("test settings done");
    for (int c = 0; c <= 8; c++) begin
      wr(OFS_PUNITS, c);
      wr(OFS_AUNITS, 8 - c);
      repeat (30) @(posedge pclk);
      chk("units", disp.units, c);
    end
    press(1);
    chk("alt_on", {disp.alt_units, disp.units}, 5'h10);
    press(1);
    chk("alt_off", {disp.alt_units, disp.units}, 5'h08);
    wr(OFS_PDEC, 2);
    wr(OFS_PCOUNTBY, 5);
    repeat (30) @(posedge pclk);
    chk("dec_pos", disp.dec_pos, 2);
    chk("count_by", disp.count_by, 5);
    wr(OFS_FSWEIGHT, 600);
    wr(OFS_PCOUNTBY, 2);
    repeat (60) @(posedge pclk);
    rd(OFS_GRADS, 300);
    wr(OFS_FSWEIGHT, 10000);
    wr(OFS_PCOUNTBY, 1);
    $display("test units done");
    m = cal_cnt;
    wr(OFS_ACCESS, 1);
    wr(OFS_CALFN, 60);
    lock_unlocked <= 1'b1;
    wr(OFS_ACCESS, 0);
    wr(OFS_CALFN, 61);
    wr(OFS_ACCESS, 1);
    rd(OFS_ACCESS, 3);
    rd(OFS_STATUS, 32'h48);
    for (int f = 59; f <= 64; f++) wr(OFS_CALFN, f);
    chk("cal_pulses", cal_cnt - m, 4);
    $display("test access done");
    wr(OFS_FILTER, 0);
    wr(OFS_MDELAY, 2);
    wr(OFS_MBAND, 8);
    wr(OFS_BLANK, 1);
    wr(OFS_ZTBAND, 0);
    foreach (lv[i]) begin
      if (i == 3) wr(OFS_BLANK, 0);
      if (i == 4) wr(OFS_MDELAY, 0);
      m = mot_cnt;
      b = blk_cnt;
      load <= 24'(lv[i]);
      repeat (200) @(posedge pclk);
      chk("motion_seen", mot_cnt > m, em[i]);
      chk("blank_seen", blk_cnt > b, eb[i]);
      chk("motion_end", motion, 0);
    end
    rd(OFS_WEIGHT, 600);
    chk("disp_weight", disp.weight, 600);
    wr(OFS_FILTER, 18);
    load <= 24'd900;
    repeat (60) @(posedge pclk);
    apb(1'b0, OFS_WEIGHT, 32'h0);
    chk("settling", r > 600 && r < 900, 1);
    $display("test motion done");
    wr(OFS_FILTER, 0);
    wr(OFS_ZTBAND, 12);
    load <= 24'd2;
    repeat (600) @(posedge pclk);
    rd(OFS_ZERO, 2);
    wr(OFS_ZTBAND, 0);
    load <= 24'd4;
    repeat (600) @(posedge pclk);
    rd(OFS_ZERO, 2);
    wr(OFS_PBZPCT, 1);
    load <= 24'd50;
    repeat (50) @(posedge pclk);
    press(0);
    rd(OFS_ZERO, 50);
    load <= 24'd5000;
    repeat (50) @(posedge pclk);
    press(0);
    rd(OFS_ZERO, 50);
    $display("test zero done");
    finish_test();
  end
endmodule

// file: tb/wsc_adc_model.sv
// Load cell front end model: paced conversions of an applied load
`timescale 1ns/10ps
module wsc_adc_model #(
  parameter int W    = 24,
  parameter int CONV = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Load on the cell
  input  wire logic [W-1:0] load,
  // Conversion results
  output logic              adc_valid,
  output logic [W-1:0]      adc_data
);
  int cnt_q;
  // Strobe every CONV cycles; data is scrambled between strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 0;
      adc_valid <= 1'b0;
      adc_data  <= '0;
    end else begin
      cnt_q     <= (cnt_q == CONV - 1) ? 0 : cnt_q + 1;
      adc_valid <= (cnt_q == CONV - 1);
      adc_data  <= (cnt_q == CONV - 1) ? load : ~adc_data;
    end
  end
endmodule

// file: tb/wsc_props.sv
// Port-level checker for the weight conditioning block
`timescale 1ns/10ps
module wsc_props
  import wsc_pkg::*;
#(
  parameter int          W           = 24,
  parameter int unsigned TENTH_COUNT = 10
) (
  // Bus side
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Gain, keys and display
  input wire logic [7:0]     adc_gain,
  input wire logic           units_key,
  input wire logic           lock_unlocked,
  input wire wsc_pkg::disp_t disp,
  input wire logic           motion,
  input wire logic           cal_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write strobe
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access cycle");
  chk_err_reply: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error reply malformed");
  chk_gain_top: assert property (
    wr_done && paddr == OFS_SENS && pwdata[7:0] == 8'h00 |-> ##[1:3] adc_gain == GAIN_200)
    else $error("gain for setting 0 wrong");
  chk_gain_low: assert property (
    wr_done && paddr == OFS_SENS && pwdata[7:0] == 8'h04 |-> ##[1:3] adc_gain == GAIN_25)
    else $error("gain for setting 4 wrong");
  chk_reset_gain: assert property ($rose(presetn) |-> adc_gain == GAIN_50)
    else $error("gain after reset wrong");
  chk_cal_locked: assert property (
    wr_done && paddr == OFS_CALFN && !lock_unlocked |=> !cal_start [*2])
    else $error("calibration started while locked");
  chk_cal_pulse: assert property (cal_start |=> !cal_start)
    else $error("calibration start too long");
  chk_units_toggle: assert property (
    units_key |=> ##1 disp.alt_units != $past(disp.alt_units, 2))
    else $error("units key did not toggle");
  chk_blank_cause: assert property ($rose(disp.blank) |-> motion || $past(motion))
    else $error("blanking without motion");
endmodule
////////////////////////////////////////////////////////////////////////////
bind weight_signal_conditioning wsc_props #(.W(W), .TENTH_COUNT(TENTH_COUNT)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_gain(adc_gain), .units_key(units_key), .lock_unlocked(lock_unlocked),
  .disp(disp), .motion(motion), .cal_start(cal_start)
);
